// ===== mefq_map.svh
// constants for the emergency-stop and triggered queue block
`ifndef MEFQ_MAP_SVH
`define MEFQ_MAP_SVH
`define MEFQ_CAUSE_W 9
`define MEFQ_BIT_LOSS_FB 0
`define MEFQ_BIT_EXCESS 1
`define MEFQ_BIT_OVERFLOW 2
`define MEFQ_BIT_USER 3
`define MEFQ_BIT_DRV_ESTOP 4
`define MEFQ_BIT_SYNC 5
`define MEFQ_BIT_UPDATE 6
`define MEFQ_BIT_DRV_FAULT 7
`define MEFQ_BIT_COMM 8
`define MEFQ_BIT_ANY 15
`define MEFQ_CAUSE_RST 9'h000
`define MEFQ_WORD_RST 16'h0000
`define MEFQ_EVENT_HOLD 8
`define MEFQ_POST_TRIGGER_DISTANCE_LIMIT 4194303
`define MEFQ_WRONG_LIMIT 65535
`define MEFQ_ACT_START 2'h0
`define MEFQ_ACT_SWITCH 2'h1
`define MEFQ_ACT_END 2'h2
`endif

// ===== mefq_pkg.sv
// types shared by the emergency-stop and triggered queue block
`default_nettype none
package mefq_pkg;
    typedef enum logic [1:0] {
        ARM_IDLE,
        ARM_WAIT_FAST,
        ARM_WAIT_POST_TRIGGER_DISTANCE
    } mefq_arm_state_type;
endpackage
`default_nettype wire

// ===== mefq_fast_if.sv
// carries the update tick and the fast-input event between modules
`timescale 1ns/1ps
`default_nettype none
interface mefq_fast_if;
    logic tick;
    logic event_bit;
    logic event_rise;
    modport src (input tick, output event_bit, output event_rise);
    modport dst (output tick, input event_bit, input event_rise);
endinterface
`default_nettype wire

// ===== mefq_sync.sv
// two flip-flop synchroniser for a pin level
`timescale 1ns/1ps
`default_nettype none
module mefq_sync (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic pin,
    output logic level
);
    logic meta;
    // first stage is read only by the second stage
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            meta <= 1'b0;
            level <= 1'b0;
        end else if (ce) begin
            meta <= pin;
            level <= meta;
        end
    end
endmodule
`default_nettype wire

// ===== mefq_fast_event.sv
// fast-input event bit, held for a fixed number of updates
`timescale 1ns/1ps
`default_nettype none
`include "mefq_map.svh"
module mefq_fast_event #(
    parameter int HOLD = `MEFQ_EVENT_HOLD
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic fast_level,
    mefq_fast_if.src ev
);
    localparam int CW = $clog2(HOLD + 1);
    logic prev_level;
    logic [CW-1:0] count;
    // refuse a hold time the counter cannot serve
    if (HOLD < 1) begin : g_bad_hold
        $error("mefq_fast_event: HOLD must be at least one");
    end
    // an edge while the bit is on is lost, so events need spacing
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prev_level <= 1'b0;
            count <= '0;
            ev.event_bit <= 1'b0;
            ev.event_rise <= 1'b0;
        end else if (ce && ev.tick) begin
            prev_level <= fast_level;
            ev.event_rise <= 1'b0;
            if (fast_level && !prev_level && !ev.event_bit) begin
                ev.event_bit <= 1'b1;
                ev.event_rise <= 1'b1;
                count <= CW'(HOLD - 1);
            end else if (count != '0) begin
                count <= count - 1'b1;
            end else begin
                ev.event_bit <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ===== mefq_top.sv
// per-axis emergency-stop supervision and fast-input triggered queue
// Summary of operation
// - reset command clears the emergency stop and every cause bit behind it except the link error
// - resumable stop keeps both queues on reset; otherwise both are flushed
// - reset re-closes the loop only if it was closed before the stop
// - on a digital drive axis reset also clears the drive faults
// - drive link error survives reset; only the link restart clears it
// - stop command opens the servo loop and zeroes the analog command
// - with resume permission set, stop command also enters resume mode
// - status flag is high whenever any stop is active
// - wrong-way travel beyond the limit while armed raises programming error
// - queue action waits for fast input and then the programmed distance
// - event bit lasts eight updates; events need nine updates of spacing
// - start action holds the start of the next move; earlier fast inputs are ignored
// - switch action aborts the running move and starts the next one, if one is queued
// - if the first move ends before the trigger, next starts normally
// - end action stops the move, or starts the next move if queued
// - with no fast input the ended move completes normally
// - arming with trigger axis zero cancels the hold at once
// - programming error stays latched until its clear command
// - managed axis and trigger axis may be the same or different
// - cause word: bit 15 for any stop, low nine bits per cause
`timescale 1ns/1ps
`default_nettype none
`include "mefq_map.svh"
module mefq_top
    import mefq_pkg::*;
#(
    parameter int POS_W = 32
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic tick,
    input wire logic estop_cmd,
    input wire logic estop_reset_cmd,
    input wire logic loop_close_cmd,
    input wire logic drive_link_restart_cmd,
    input wire logic resume_allow,
    input wire logic digital_drive,
    input wire logic [`MEFQ_CAUSE_W-1:0] fault_in,
    input wire logic triggered_queue_arm_cmd,
    input wire logic [7:0] arm_trig_axis,
    input wire logic [1:0] arm_action,
    input wire logic signed [22:0] post_trigger_distance,
    input wire logic prog_err_clear_cmd,
    input wire logic queue_flush_cmd,
    input wire logic fast_pin,
    input wire logic signed [POS_W-1:0] trig_pos,
    input wire logic move_busy,
    input wire logic next_valid,
    output logic estop_active_flag,
    output logic [15:0] stop_cause_word,
    output logic loop_closed,
    output logic cmd_zero,
    output logic resume_mode,
    output logic drive_fault_clear,
    output logic queue_flush,
    output logic armed,
    output logic hold_start,
    output logic q_start,
    output logic q_switch,
    output logic q_stop,
    output logic prog_err
);
    logic fast_level;
    logic upd;
    logic [`MEFQ_CAUSE_W-1:0] cause;
    logic [`MEFQ_CAUSE_W-1:0] next_cause;
    logic next_any;
    logic loop_memory;
    mefq_arm_state_type arm_state;
    logic [1:0] action;
    logic signed [POS_W-1:0] ref_pos;
    logic signed [POS_W-1:0] post_trigger_distance_ext;
    logic signed [POS_W-1:0] travel;
    logic wrong_way;
    logic post_trigger_distance_met;
    logic fire;
    logic arm_new;
    logic arm_cancel;
    mefq_fast_if fast_bus ();

    // refuse a position width too narrow for the distance range
    if (POS_W < 24) begin : g_bad_pos_w
        $error("mefq_top: POS_W must be at least 24");
    end

    mefq_sync u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .ce(ce),
        .pin(fast_pin),
        .level(fast_level)
    );

    mefq_fast_event #(
        .HOLD(`MEFQ_EVENT_HOLD)
    ) u_event (
        .clk(clk),
        .sys_rst(sys_rst),
        .ce(ce),
        .fast_level(fast_level),
        .ev(fast_bus)
    );

    // every decision is qualified by the update tick
    assign upd = ce && tick;
    assign fast_bus.tick = tick;

    // cause bits: clears first, then new causes, so a set wins
    always_comb begin
        next_cause = cause;
        if (upd) begin
            // reset clears all but the link error
            if (estop_reset_cmd) begin
                next_cause = cause & (`MEFQ_CAUSE_W'(1) << `MEFQ_BIT_COMM);
            end
            // link error needs the link restart
            if (drive_link_restart_cmd) begin
                next_cause[`MEFQ_BIT_COMM] = 1'b0;
            end
            next_cause = next_cause | fault_in;
            if (estop_cmd) begin
                next_cause[`MEFQ_BIT_USER] = 1'b1;
            end
        end
    end
    assign next_any = |next_cause;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cause <= `MEFQ_CAUSE_RST;
            stop_cause_word <= `MEFQ_WORD_RST;
            estop_active_flag <= 1'b0;
        end else if (ce) begin
            cause <= next_cause;
            stop_cause_word <= {next_any, 6'h00, next_cause};
            estop_active_flag <= next_any;
        end
    end

    // loop open and command zeroed while stopped; re-close
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            loop_closed <= 1'b0;
            loop_memory <= 1'b0;
            cmd_zero <= 1'b1;
        end else if (ce) begin
            cmd_zero <= next_any;
            if (next_any) begin
                loop_closed <= 1'b0;
                if (!estop_active_flag) begin
                    loop_memory <= loop_closed;
                end
            end else if (estop_active_flag) begin
                loop_closed <= loop_memory;
            end else if (upd && loop_close_cmd) begin
                loop_closed <= 1'b1;
            end
        end
    end

    // resume mode entry, left on reset
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            resume_mode <= 1'b0;
        end else if (upd) begin
            if (estop_cmd && resume_allow) begin
                resume_mode <= 1'b1;
            end else if (estop_reset_cmd) begin
                resume_mode <= 1'b0;
            end
        end
    end

    // flush on non-resumable reset; drive fault clear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            queue_flush <= 1'b0;
            drive_fault_clear <= 1'b0;
        end else if (ce) begin
            queue_flush <= upd && (queue_flush_cmd || (estop_reset_cmd &&
                estop_active_flag && !resume_mode));
            drive_fault_clear <= upd && estop_reset_cmd && digital_drive;
        end
    end

    // travel of the trigger axis from the current reference point
    assign post_trigger_distance_ext = POS_W'(post_trigger_distance);
    assign travel = trig_pos - ref_pos;
    // opposite travel beyond the limit, zero distance counts positive
    assign wrong_way = post_trigger_distance_ext[POS_W-1] ?
        (travel > POS_W'(`MEFQ_WRONG_LIMIT)) :
        (travel < -POS_W'(`MEFQ_WRONG_LIMIT));
    // distance reached in the requested direction
    assign post_trigger_distance_met = post_trigger_distance_ext[POS_W-1] ? (travel <= post_trigger_distance_ext) :
        (travel >= post_trigger_distance_ext);
    assign fire = upd && arm_state == ARM_WAIT_POST_TRIGGER_DISTANCE && post_trigger_distance_met;
    // trigger axis is any nonzero number, own axis allowed
    assign arm_new = upd && triggered_queue_arm_cmd && arm_trig_axis != 8'h00;
    assign arm_cancel = upd && triggered_queue_arm_cmd &&
        arm_trig_axis == 8'h00;

    // hold state machine
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            arm_state <= ARM_IDLE;
            action <= `MEFQ_ACT_START;
            ref_pos <= '0;
        end else if (ce) begin
            if (arm_cancel) begin
                arm_state <= ARM_IDLE;
            end else if (arm_new) begin
                // arming restarts the wait; older events not counted
                arm_state <= ARM_WAIT_FAST;
                action <= arm_action;
                ref_pos <= trig_pos;
            end else if (upd) begin
                case (arm_state)
                    ARM_IDLE: begin
                        arm_state <= ARM_IDLE;
                    end
                    ARM_WAIT_FAST: begin
                        // move ended first, run the queue unarmed
                        if (action != `MEFQ_ACT_START && !move_busy) begin
                            arm_state <= ARM_IDLE;
                        end else if (fast_bus.event_rise) begin
                            arm_state <= ARM_WAIT_POST_TRIGGER_DISTANCE;
                            ref_pos <= trig_pos;
                        end
                    end
                    ARM_WAIT_POST_TRIGGER_DISTANCE: begin
                        // move ended normally before the distance
                        if (post_trigger_distance_met) begin
                            arm_state <= ARM_IDLE;
                        end else if (action != `MEFQ_ACT_START &&
                                     !move_busy) begin
                            arm_state <= ARM_IDLE;
                        end
                    end
                    default: begin
                        arm_state <= ARM_IDLE;
                    end
                endcase
            end
        end
    end

    // queue actions issued when the hold is released
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            q_start <= 1'b0;
            q_switch <= 1'b0;
            q_stop <= 1'b0;
        end else if (ce) begin
            q_start <= fire && action == `MEFQ_ACT_START;
            // abort and switch; end hands over to a queued move
            q_switch <= fire && action != `MEFQ_ACT_START && next_valid;
            // end with nothing queued stops the move
            q_stop <= fire && action == `MEFQ_ACT_END && !next_valid;
        end
    end

    // hold indication to the queue manager
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            armed <= 1'b0;
            hold_start <= 1'b0;
        end else if (ce) begin
            armed <= arm_state != ARM_IDLE;
            hold_start <= arm_state != ARM_IDLE &&
                action == `MEFQ_ACT_START;
        end
    end

    // programming error latch, set wins over clear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prog_err <= 1'b0;
        end else if (upd) begin
            if (arm_state != ARM_IDLE && wrong_way) begin
                prog_err <= 1'b1;
            end else if (prog_err_clear_cmd) begin
                prog_err <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence seq_reset_taken;
        upd && estop_reset_cmd && fault_in == '0 && !estop_cmd;
    endsequence
    sequence seq_armed_fire;
        arm_state == ARM_WAIT_POST_TRIGGER_DISTANCE ##1 q_start || q_switch || q_stop;
    endsequence

    a_flag_word: assert property (
        estop_active_flag == stop_cause_word[`MEFQ_BIT_ANY] &&
        estop_active_flag == (stop_cause_word[8:0] != 9'h000))
        else $error("status flag disagrees with cause word");
    a_reset_clears: assert property (
        seq_reset_taken |=> stop_cause_word[7:0] == 8'h00)
        else $error("reset left a cause bit set");
    a_comm_kept: assert property (
        seq_reset_taken ##0 !drive_link_restart_cmd &&
        stop_cause_word[8] |=> stop_cause_word[8])
        else $error("link error cleared by reset");
    a_stop_entry: assert property (
        upd && estop_cmd |=> estop_active_flag && !loop_closed && cmd_zero)
        else $error("stop did not open loop");
    a_resume_entry: assert property (
        upd && estop_cmd && resume_allow |=> resume_mode)
        else $error("resume mode not entered");
    a_flush_kind: assert property (
        upd && estop_reset_cmd && estop_active_flag |=>
        queue_flush == (!$past(resume_mode) || $past(queue_flush_cmd)))
        else $error("queue flush wrong for stop kind");
    a_drive_clear: assert property (
        upd && estop_reset_cmd |=> drive_fault_clear == $past(digital_drive))
        else $error("drive fault clear wrong");
    a_reclose: assert property (
        $fell(estop_active_flag) |-> loop_closed == $past(loop_memory))
        else $error("loop re-close wrong");
    a_err_latched: assert property (
        prog_err && !(upd && prog_err_clear_cmd) |=> prog_err)
        else $error("programming error dropped");
    a_cancel_hold: assert property (
        arm_cancel |=> arm_state == ARM_IDLE ##1 !armed && !hold_start)
        else $error("cancel did not release hold");
    a_fire_armed: assert property (
        $rose(q_start || q_switch || q_stop) |->
        $past(arm_state) == ARM_WAIT_POST_TRIGGER_DISTANCE)
        else $error("queue action without trigger");
    a_fire_seq: cover property (seq_armed_fire);
endmodule
`default_nettype wire

// ===== mefq_drive_model.sv
// servo drive and feedback module model with a fast input pin
`timescale 1ns/1ps
`default_nettype none
module mefq_drive_model (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic tick,
    input wire logic signed [31:0] vel,
    input wire logic fire,
    input wire logic start_move,
    input wire logic [7:0] move_len,
    input wire logic q_start,
    input wire logic q_switch,
    input wire logic q_stop,
    output logic signed [31:0] trig_pos,
    output logic fast_pin,
    output logic move_busy
);
    logic [3:0] pin_cnt;
    logic [7:0] left;
    // position steps on the update tick shared with the axis
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            trig_pos <= 32'sh0000_1000;
        end else if (tick) begin
            trig_pos <= trig_pos + vel;
        end
    end
    // fast pin high for three updates, requests spaced by the bench
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fast_pin <= 1'b0;
            pin_cnt <= 4'h0;
        end else if (fire && !fast_pin) begin
            fast_pin <= 1'b1;
            pin_cnt <= 4'h3;
        end else if (tick && fast_pin) begin
            pin_cnt <= pin_cnt - 4'h1;
            fast_pin <= (pin_cnt != 4'h1);
        end
    end
    // move runs for move_len updates unless stopped early
    always_ff @(posedge clk) begin
        if (sys_rst || q_stop) begin
            move_busy <= 1'b0;
            left <= 8'h00;
        end else if (start_move || q_start || q_switch) begin
            move_busy <= 1'b1;
            left <= move_len;
        end else if (tick && move_busy) begin
            left <= left - 8'h01;
            move_busy <= (left != 8'h01);
        end
    end
endmodule
`default_nettype wire

// ===== testbench.sv
// self-checking bench for stop supervision and the triggered queue
`timescale 1ns/1ps
`default_nettype none
`include "mefq_map.svh"
`define CHK(a, b) \
    begin \
        n_checks++; \
        if ((a) !== (b)) begin \
            miscompares++; \
            $display("CHECK FAILED at %0t got %h expected %h", \
                $time, a, b); \
        end \
    end
module testbench;
    typedef struct packed {
        logic [8:0] f;
        logic est;
        logic res;
        logic dig;
        logic lc;
        logic [15:0] w;
    } mefq_row_type;
    // cause inputs, stop flags and the word each should give
    mefq_row_type rows [11] = '{
        {9'h001, 4'b0000, 16'h8001}, {9'h002, 4'b0010, 16'h8002},
        {9'h004, 4'b0000, 16'h8004}, {9'h010, 4'b0010, 16'h8010},
        {9'h020, 4'b0000, 16'h8020}, {9'h000, 4'b1000, 16'h8008},
        {9'h040, 4'b0011, 16'h8040}, {9'h080, 4'b0011, 16'h8080},
        {9'h100, 4'b0001, 16'h8100}, {9'h00a, 4'b0001, 16'h800a},
        {9'h000, 4'b1111, 16'h8008}};
    mefq_row_type r;
    logic clk = 1'b0, sys_rst = 1'b1, ce = 1'b1, tick = 1'b0;
    logic estop_cmd = 1'b0, estop_reset_cmd = 1'b0, loop_close_cmd = 1'b0;
    logic drive_link_restart_cmd = 1'b0, triggered_queue_arm_cmd = 1'b0;
    logic prog_err_clear_cmd = 1'b0, queue_flush_cmd = 1'b0;
    logic resume_allow = 1'b0, digital_drive = 1'b0, next_valid = 1'b0;
    logic fire = 1'b0, start_move = 1'b0;
    logic [8:0] fault_in = 9'h000;
    logic [7:0] arm_trig_axis = 8'h00, move_len = 8'h00;
    logic [1:0] arm_action = 2'h0;
    logic signed [22:0] post_trigger_distance = 23'sh0;
    logic signed [31:0] vel = 32'sh0, trig_pos;
    logic fast_pin, move_busy, estop_active_flag, loop_closed, cmd_zero;
    logic resume_mode, drive_fault_clear, queue_flush, armed, hold_start;
    logic q_start, q_switch, q_stop, prog_err;
    logic [15:0] stop_cause_word;
    int n_qs = 0, n_qw = 0, n_qp = 0, n_fl = 0, n_df = 0, cyc = 0;
    int miscompares = 0, n_checks = 0, nf, nd, sw, st, base;

    mefq_top #(.POS_W(32)) dut (.clk, .sys_rst, .ce, .tick, .estop_cmd,
        .estop_reset_cmd, .loop_close_cmd, .drive_link_restart_cmd,
        .resume_allow, .digital_drive, .fault_in, .triggered_queue_arm_cmd,
        .arm_trig_axis, .arm_action, .post_trigger_distance,
        .prog_err_clear_cmd, .queue_flush_cmd, .fast_pin, .trig_pos,
        .move_busy, .next_valid, .estop_active_flag, .stop_cause_word,
        .loop_closed, .cmd_zero, .resume_mode, .drive_fault_clear,
        .queue_flush, .armed, .hold_start, .q_start, .q_switch, .q_stop,
        .prog_err);
    mefq_drive_model drv (.clk, .sys_rst, .tick, .vel, .fire, .start_move,
        .move_len, .q_start, .q_switch, .q_stop, .trig_pos, .fast_pin,
        .move_busy);

    // clock generator
    initial begin
        forever #25 clk = ~clk;
    end

    // count the one-clock pulses and cut a hang short
    always @(posedge clk) begin
        n_qs <= n_qs + int'(q_start);
        n_qw <= n_qw + int'(q_switch);
        n_qp <= n_qp + int'(q_stop);
        n_fl <= n_fl + int'(queue_flush);
        n_df <= n_df + int'(drive_fault_clear);
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            miscompares++;
            end_of_test();
        end
    end

    task end_of_test;
        if (miscompares == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // one update tick every four clocks; one-shot commands drop after it
    task tk(input int n);
        repeat (n) begin
            @(posedge clk);
            tick <= 1'b1;
            @(posedge clk);
            tick <= 1'b0;
            estop_cmd <= 1'b0;
            estop_reset_cmd <= 1'b0;
            loop_close_cmd <= 1'b0;
            drive_link_restart_cmd <= 1'b0;
            triggered_queue_arm_cmd <= 1'b0;
            prog_err_clear_cmd <= 1'b0;
            queue_flush_cmd <= 1'b0;
            fire <= 1'b0;
            start_move <= 1'b0;
            repeat (2) @(posedge clk);
        end
    endtask

    // distance kept inside the accepted range by the callers
    task arm(input logic [7:0] ax, input logic [1:0] act, input int d);
        triggered_queue_arm_cmd <= 1'b1;
        arm_trig_axis <= ax;
        arm_action <= act;
        post_trigger_distance <= 23'(d);
        tk(1);
    endtask

    initial begin
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        tk(1);
        `CHK({estop_active_flag, cmd_zero, prog_err}, 3'b000)
        `CHK(stop_cause_word, 16'h0000)
        foreach (rows[i]) begin
            r = rows[i];
            resume_allow <= r.res;
            digital_drive <= r.dig;
            loop_close_cmd <= r.lc;
            tk(1);
            fault_in <= r.f;
            estop_cmd <= r.est;
            tk(1);
            fault_in <= 9'h000;
            `CHK(stop_cause_word, r.w)
            `CHK(estop_active_flag, 1'b1)
            `CHK({loop_closed, cmd_zero}, 2'b01)
            `CHK(resume_mode, r.res)
            nf = n_fl;
            nd = n_df;
            estop_reset_cmd <= 1'b1;
            tk(1);
            `CHK(stop_cause_word, r.f[8] ? 16'h8100 : 16'h0000)
            `CHK(loop_closed, r.lc & ~r.f[8])
            `CHK(resume_mode, 1'b0)
            `CHK(n_fl - nf, int'(!r.res))
            `CHK(n_df - nd, int'(r.dig))
            drive_link_restart_cmd <= 1'b1;
            tk(1);
            `CHK({estop_active_flag, stop_cause_word}, 17'h00000)
        end
        // a command away from the update tick is dropped
        estop_cmd <= 1'b1;
        @(posedge clk);
        estop_cmd <= 1'b0;
        tk(1);
        `CHK(estop_active_flag, 1'b0)
        // with the clock enable low a tick is not seen
        ce <= 1'b0;
        estop_cmd <= 1'b1;
        tk(1);
        ce <= 1'b1;
        `CHK(estop_active_flag, 1'b0)
        // a fast input before arming is ignored; the next one triggers
        vel <= 32'sd20;
        fire <= 1'b1;
        tk(10);
        arm(8'h01, `MEFQ_ACT_START, 100);
        `CHK({armed, hold_start}, 2'b11)
        base = n_qs;
        tk(6);
        `CHK(n_qs, base)
        fire <= 1'b1;
        tk(3);
        `CHK(n_qs, base)
        tk(10);
        `CHK(n_qs, base + 1)
        `CHK(armed, 1'b0)
        // trigger during a running move: switch to a queued move, end,
        // end with next queued
        for (int k = 0; k < 3; k++) begin
            next_valid <= (k != 1);
            move_len <= 8'hc8;
            start_move <= 1'b1;
            tk(1);
            arm(8'h01, k == 0 ? `MEFQ_ACT_SWITCH : `MEFQ_ACT_END, 0);
            sw = n_qw;
            st = n_qp;
            fire <= 1'b1;
            tk(10);
            `CHK(n_qw - sw, int'(k != 1))
            `CHK(n_qp - st, int'(k == 1))
            `CHK(move_busy, k != 1)
        end
        // move finishes before any fast input: hold drops, nothing forced
        for (int k = 1; k < 3; k++) begin
            next_valid <= 1'b0;
            move_len <= 8'h03;
            start_move <= 1'b1;
            tk(1);
            arm(8'h01, 2'(k), 0);
            sw = n_qw + n_qp;
            tk(6);
            `CHK({move_busy, armed}, 2'b00)
            `CHK(n_qw + n_qp, sw)
        end
        // arming with axis zero releases the hold
        arm(8'h01, `MEFQ_ACT_START, 100);
        `CHK({armed, hold_start}, 2'b11)
        arm(8'h00, `MEFQ_ACT_START, 0);
        `CHK({armed, hold_start}, 2'b00)
        // wrong-way travel: exactly the limit passes, one unit more trips
        vel <= 32'sd0;
        arm(8'h01, `MEFQ_ACT_START, 100);
        vel <= -32'sd65535;
        tk(1);
        vel <= 32'sd0;
        tk(2);
        `CHK(prog_err, 1'b0)
        vel <= -32'sd1;
        tk(1);
        vel <= 32'sd0;
        tk(2);
        `CHK(prog_err, 1'b1)
        nf = n_fl;
        // queues flushed once the programming error shows
        queue_flush_cmd <= 1'b1;
        tk(1);
        `CHK(n_fl - nf, 1)
        arm(8'h00, `MEFQ_ACT_START, 0);
        tk(2);
        `CHK(prog_err, 1'b1)
        prog_err_clear_cmd <= 1'b1;
        tk(1);
        `CHK(prog_err, 1'b0)
        // second reset in mid-run while stopped
        estop_cmd <= 1'b1;
        tk(1);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        `CHK({estop_active_flag, cmd_zero, stop_cause_word}, 18'h10000)
        sys_rst <= 1'b0;
        tk(1);
        `CHK(cmd_zero, 1'b0)
        end_of_test();
    end
endmodule
`default_nettype wire
